// ===== fbpc_core.sv
// fetch, decode and execute logic of the four-bit processor core
// assumes memory chips answer on bus_in during the two fetch phases and x2
module fbpc_core (
  input  wire logic                mclk,
  input  wire logic                srst,
  input  wire logic                test_in,
  input  wire logic [3:0]          bus_in,
  output fbpc_pkg::fbpc_bus_t      bus_drive,
  output logic                     cycle_sync,
  output logic                     program_memory_select,
  output logic [3:0]               data_bank_select
);

  fbpc_pkg::fbpc_state_t s_q;
  fbpc_pkg::fbpc_state_t s_d;
  logic                  plain;
  logic [3:0]            op;
  logic [3:0]            md;
  logic [3:0]            pev;
  logic [3:0]            pod;
  logic [3:0]            fev;
  logic [3:0]            fod;
  logic [3:0]            reg_md;
  logic [3:0]            bump_val;
  logic                  two_word;
  logic                  cond_true;
  logic [1:0]            sp_up;
  logic [1:0]            sp_dn;
  logic [4:0]            sum;
  logic                  s_d_plain;

  function automatic logic [3:0] bank_lines(input logic [2:0] code);
    return (code == 3'h0) ? fbpc_pkg::BANK_LINE_ZERO : {code, 1'b0};
  endfunction

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  assign plain    = !s_q.second_word && !s_q.fetch_indirect;
  assign op       = s_q.operation_nibble;
  assign md       = s_q.modifier_nibble;
  assign pev      = {md[3:1], 1'b0};
  assign pod      = {md[3:1], 1'b1};
  assign fev      = {s_q.first_word[3:1], 1'b0};
  assign fod      = {s_q.first_word[3:1], 1'b1};
  assign reg_md   = s_q.regs[md];
  assign bump_val = s_q.regs[s_q.first_word[3:0]] + 4'h1;
  assign sp_up    = (s_q.sp == fbpc_pkg::STACK_TOP) ? 2'h0 : s_q.sp + 2'h1;
  assign sp_dn    = (s_q.sp == 2'h0) ? fbpc_pkg::STACK_TOP : s_q.sp - 2'h1;
  assign two_word = (op == fbpc_pkg::OP_JUMP_COND) || (op == fbpc_pkg::OP_JUMP_ABS)
                 || (op == fbpc_pkg::OP_CALL) || (op == fbpc_pkg::OP_BUMP_SKIP)
                 || (op == fbpc_pkg::OP_PAIR_IMM && !md[0]);
  // invert, accumulator zero, carry, test
  assign cond_true = s_q.first_word[3] ^ ((s_q.first_word[2] && s_q.acc == 4'h0)
                  || (s_q.first_word[1] && s_q.cy)
                  || (s_q.first_word[0] && test_in));

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    sum = 5'h00;
    s_d.phase = fbpc_pkg::fbpc_phase_t'(s_q.phase + 3'h1);
    unique case (s_q.phase)
      fbpc_pkg::PH_FIRST_FETCH: s_d.operation_nibble = bus_in;
      fbpc_pkg::PH_SECOND_FETCH: begin
        s_d.modifier_nibble = bus_in;
        if (!s_q.fetch_indirect) begin
          s_d.pc = s_q.pc + 12'h001;
        end
      end
      fbpc_pkg::PH_X1: begin
        if (s_q.fetch_indirect) begin
          s_d.regs[fev] = op;
          s_d.regs[fod] = md;
        end else if (s_q.second_word) begin
          case (s_q.first_word[7:4])
            fbpc_pkg::OP_JUMP_COND: begin
              if (cond_true) begin
                s_d.pc = {s_q.pc[11:8], op, md};
              end
            end
            fbpc_pkg::OP_PAIR_IMM: begin
              s_d.regs[fev] = op;
              s_d.regs[fod] = md;
            end
            fbpc_pkg::OP_JUMP_ABS: s_d.pc = {s_q.first_word[3:0], op, md};
            fbpc_pkg::OP_CALL: begin
              s_d.stack[s_q.sp] = s_q.pc;
              s_d.sp = sp_up;
              s_d.pc = {s_q.first_word[3:0], op, md};
            end
            fbpc_pkg::OP_BUMP_SKIP: begin
              s_d.regs[s_q.first_word[3:0]] = bump_val;
              if (bump_val != 4'h0) begin
                s_d.pc = {s_q.pc[11:8], op, md};
              end
            end
            default: ;
          endcase
        end else begin
          case (op)
            fbpc_pkg::OP_PAIR_IND: begin
              if (md[0]) begin
                s_d.pc = {s_q.pc[11:8], s_q.regs[pev], s_q.regs[pod]};
              end
            end
            fbpc_pkg::OP_INC: s_d.regs[md] = reg_md + 4'h1;
            fbpc_pkg::OP_ADD: begin
              sum = {1'b0, s_q.acc} + {1'b0, reg_md} + {4'h0, s_q.cy};
              s_d.acc = sum[3:0];
              s_d.cy = sum[4];
            end
            fbpc_pkg::OP_SUB: begin
              sum = {1'b0, s_q.acc} + {1'b0, ~reg_md} + {4'h0, ~s_q.cy};
              s_d.acc = sum[3:0];
              s_d.cy = sum[4];
            end
            fbpc_pkg::OP_LOAD: s_d.acc = reg_md;
            fbpc_pkg::OP_SWAP: begin
              s_d.acc = reg_md;
              s_d.regs[md] = s_q.acc;
            end
            fbpc_pkg::OP_RETURN: begin
              s_d.sp = sp_dn;
              s_d.pc = s_q.stack[sp_dn];
              s_d.acc = md;
            end
            fbpc_pkg::OP_LOAD_IMM: s_d.acc = md;
            fbpc_pkg::OP_ACC_GROUP: begin
              case (md)
                fbpc_pkg::AG_CLEAR_BOTH: {s_d.cy, s_d.acc} = 5'h00;
                fbpc_pkg::AG_CLEAR_CARRY: s_d.cy = 1'b0;
                fbpc_pkg::AG_INC_ACC: {s_d.cy, s_d.acc} = {1'b0, s_q.acc} + 5'h01;
                fbpc_pkg::AG_CPL_CARRY: s_d.cy = ~s_q.cy;
                fbpc_pkg::AG_CPL_ACC: s_d.acc = ~s_q.acc;
                fbpc_pkg::AG_ROT_LEFT: {s_d.cy, s_d.acc} = {s_q.acc, s_q.cy};
                fbpc_pkg::AG_ROT_RIGHT: {s_d.acc, s_d.cy} = {s_q.cy, s_q.acc};
                fbpc_pkg::AG_CARRY_TO_A: {s_d.cy, s_d.acc} = {4'h0, s_q.cy};
                fbpc_pkg::AG_DEC_ACC: {s_d.cy, s_d.acc} = {1'b0, s_q.acc} + 5'h0F;
                fbpc_pkg::AG_CARRY_SUB: begin
                  s_d.acc = s_q.cy ? fbpc_pkg::CARRY_SUB_ONE : fbpc_pkg::CARRY_SUB_ZERO;
                  s_d.cy = 1'b0;
                end
                fbpc_pkg::AG_SET_CARRY: s_d.cy = 1'b1;
                fbpc_pkg::AG_DEC_ADJUST: begin
                  if (s_q.acc > fbpc_pkg::DEC_LIMIT || s_q.cy) begin
                    sum = {1'b0, s_q.acc} + {1'b0, fbpc_pkg::DEC_CORRECTION};
                    s_d.acc = sum[3:0];
                    s_d.cy = s_q.cy | sum[4];
                  end
                end
                fbpc_pkg::AG_ONE_HOT_BIN: begin
                  case (s_q.acc)
                    4'h0, 4'h1, 4'h2: s_d.acc = s_q.acc;
                    4'h4: s_d.acc = 4'h3;
                    4'h8: s_d.acc = 4'h4;
                    default: s_d.acc = fbpc_pkg::ONE_HOT_BAD;
                  endcase
                end
                fbpc_pkg::AG_CHOOSE_BANK: s_d.bank_code = s_q.acc[2:0];
                default: ;
              endcase
            end
            default: ;
          endcase
        end
      end
      fbpc_pkg::PH_X2: begin
        // reads of the addressed character, status or port
        if (plain && op == fbpc_pkg::OP_IO && md[3]) begin
          if (md == fbpc_pkg::IO_SUB_CHAR) begin
            sum = {1'b0, s_q.acc} + {1'b0, ~bus_in} + {4'h0, ~s_q.cy};
            s_d.acc = sum[3:0];
            s_d.cy = sum[4];
          end else if (md == fbpc_pkg::IO_ADD_CHAR) begin
            sum = {1'b0, s_q.acc} + {1'b0, bus_in} + {4'h0, s_q.cy};
            s_d.acc = sum[3:0];
            s_d.cy = sum[4];
          end else begin
            s_d.acc = bus_in;
          end
        end
      end
      fbpc_pkg::PH_X3: begin
        s_d.first_word = {op, md};
        s_d.second_word = plain && two_word;
        s_d.fetch_indirect = plain && op == fbpc_pkg::OP_PAIR_IND && !md[0];
      end
      fbpc_pkg::PH_A1, fbpc_pkg::PH_A2, fbpc_pkg::PH_A3: ;
    endcase

    // ---------------------------------------------------------------
    // pin drive for the phase being entered
    // ---------------------------------------------------------------
    s_d_plain = !s_d.second_word && !s_d.fetch_indirect;
    s_d.sync = 1'b0;
    s_d.bus = '0;
    s_d.rom_sel = 1'b0;
    s_d.bank_sel = 4'h0;
    unique case (s_d.phase)
      fbpc_pkg::PH_A1: begin
        s_d.sync = 1'b1;
        s_d.bus.oe = 1'b1;
        s_d.bus.data = s_d.fetch_indirect ? s_d.regs[1] : s_d.pc[3:0];
      end
      fbpc_pkg::PH_A2: begin
        s_d.bus.oe = 1'b1;
        s_d.bus.data = s_d.fetch_indirect ? s_d.regs[0] : s_d.pc[7:4];
      end
      fbpc_pkg::PH_A3: begin
        s_d.bus.oe = 1'b1;
        s_d.bus.data = s_d.pc[11:8];
        s_d.rom_sel = 1'b1;
        s_d.bank_sel = bank_lines(s_d.bank_code);
      end
      fbpc_pkg::PH_SECOND_FETCH: begin
        if (s_d_plain && s_d.operation_nibble == fbpc_pkg::OP_IO) begin
          s_d.rom_sel = 1'b1;
          s_d.bank_sel = bank_lines(s_d.bank_code);
        end
      end
      fbpc_pkg::PH_X2: begin
        if (s_d_plain && op == fbpc_pkg::OP_PAIR_IMM && md[0]) begin
          s_d.bus.oe = 1'b1;
          s_d.bus.data = s_d.regs[pev];
          s_d.rom_sel = 1'b1;
          s_d.bank_sel = bank_lines(s_d.bank_code);
        end else if (s_d_plain && op == fbpc_pkg::OP_IO && !md[3]) begin
          s_d.bus.oe = 1'b1;
          s_d.bus.data = s_d.acc;
        end
      end
      fbpc_pkg::PH_X3: begin
        if (s_d_plain && op == fbpc_pkg::OP_PAIR_IMM && md[0]) begin
          s_d.bus.oe = 1'b1;
          s_d.bus.data = s_d.regs[pod];
        end
      end
      fbpc_pkg::PH_FIRST_FETCH, fbpc_pkg::PH_X1: ;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_q <= fbpc_pkg::STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus_drive             = s_q.bus;
  assign cycle_sync            = s_q.sync;
  assign program_memory_select = s_q.rom_sel;
  assign data_bank_select      = s_q.bank_sel;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  property p_reset_clear;
    @(posedge mclk) disable iff (1'b0)
    srst |=> (s_q.pc == 12'h000 && !s_q.cy && s_q.acc == 4'h0 && s_q.sp == 2'h0);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear state");
  property p_sync_period;
    cycle_sync |=> !cycle_sync [*7] ##1 cycle_sync;
  endproperty
  a_sync_period: assert property (p_sync_period) else $error("sync not every 8 clocks");
  property p_rom_sel_fetch;
    (s_q.phase == fbpc_pkg::PH_A3) |-> (program_memory_select && bus_drive.oe);
  endproperty
  a_rom_sel_fetch: assert property (p_rom_sel_fetch) else $error("no memory select at a3");
  property p_bus_released;
    (s_q.phase == fbpc_pkg::PH_FIRST_FETCH || s_q.phase == fbpc_pkg::PH_SECOND_FETCH)
      |-> !bus_drive.oe;
  endproperty
  a_bus_released: assert property (p_bus_released) else $error("bus driven in fetch");
  property p_nibble_order;
    (s_q.phase == fbpc_pkg::PH_FIRST_FETCH) |=>
      (s_q.phase == fbpc_pkg::PH_SECOND_FETCH && s_q.operation_nibble == $past(bus_in));
  endproperty
  a_nibble_order: assert property (p_nibble_order) else $error("nibble order broken");
  property p_two_word;
    $rose(s_q.second_word) |-> s_q.second_word [*8] ##1 !s_q.second_word;
  endproperty
  a_two_word: assert property (p_two_word) else $error("second word cycle length");
  property p_bank_phase;
    (data_bank_select != 4'h0) |-> (s_q.phase == fbpc_pkg::PH_A3
      || s_q.phase == fbpc_pkg::PH_SECOND_FETCH || s_q.phase == fbpc_pkg::PH_X2);
  endproperty
  a_bank_phase: assert property (p_bank_phase) else $error("bank select off phase");
  property p_return_value;
    (s_q.phase == fbpc_pkg::PH_X1 && plain && op == fbpc_pkg::OP_RETURN)
      |=> (s_q.acc == $past(md) && s_q.sp == $past(sp_dn));
  endproperty
  a_return_value: assert property (p_return_value) else $error("return value wrong");
  property p_test_hold;
    (s_q.phase == fbpc_pkg::PH_X1 && s_q.second_word && s_q.first_word == 8'h11)
      |=> (s_q.pc == ($past(test_in) ? {$past(s_q.pc[11:8]), $past(op), $past(md)}
                                     : $past(s_q.pc)));
  endproperty
  a_test_hold: assert property (p_test_hold) else $error("test jump went wrong way");

endmodule

// ===== fbpc_mem.sv
// program and data memory partner of the four-bit processor core
// assumes the bench resolves the shared bus and feeds the result back to the core
module fbpc_mem (
  input  wire logic                mclk,
  input  wire logic                srst,
  input  wire fbpc_pkg::fbpc_bus_t bus_drive,
  input  wire logic                cycle_sync,
  input  wire logic                program_memory_select,
  input  wire logic [3:0]          rd_val,
  output logic                     mem_oe,
  output logic [3:0]               mem_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // program image, addresses 000 to 01F, plus 020 and 030
  // ---------------------------------------------------------------
  localparam logic [255:0] PROG =
    256'hD5E0203C21F4E0F2E0E9E05030E0111AD1401B00000000000000D2E0A081E040;

  logic [2:0]  cnt_q;
  logic [2:0]  ph;
  logic [11:0] addr_q;
  logic        sel_q;
  logic [7:0]  op_q;
  logic [7:0]  byte_v;

  function automatic logic [7:0] prog(input logic [11:0] a);
    if (a[11:5] == 7'h00) begin
      return PROG[255 - 8 * int'(a[4:0]) -: 8];
    end
    if (a == 12'h020) begin
      return 8'h1F;
    end
    if (a == 12'h030) begin
      return 8'hC7;
    end
    return 8'h00;
  endfunction

  // ---------------------------------------------------------------
  // phase tracking and address capture
  // ---------------------------------------------------------------
  assign ph = cycle_sync ? 3'h0 : cnt_q;
  assign byte_v = prog(addr_q);

  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_q <= 3'h0;
      sel_q <= 1'b0;
    end else begin
      cnt_q <= ph + 3'h1;
      if (ph == 3'h0) addr_q[3:0] <= bus_drive.data;
      if (ph == 3'h1) addr_q[7:4] <= bus_drive.data;
      if (ph == 3'h2) begin
        addr_q[11:8] <= bus_drive.data;
        sel_q        <= program_memory_select;
      end
      if (ph == 3'h4) op_q <= byte_v;
    end
  end

  // ---------------------------------------------------------------
  // bus answers: operation nibble first, modifier second, reads at x2
  // ---------------------------------------------------------------
  always_comb begin
    mem_oe   = 1'b0;
    mem_data = 4'h0;
    if (sel_q && ph == 3'h3) begin
      mem_oe   = 1'b1;
      mem_data = byte_v[7:4];
    end else if (sel_q && ph == 3'h4) begin
      mem_oe   = 1'b1;
      mem_data = byte_v[3:0];
    end else if (ph == 3'h6 && op_q[7:3] == 5'h1D) begin
      mem_oe   = 1'b1;
      mem_data = rd_val;
    end
  end
endmodule

// ===== fbpc_pkg.sv
// constants, encodings and state record of the four-bit processor core
// assumes a single 40 MHz clock; one bus phase per clock, eight phases per cycle
package fbpc_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS     = 25;
  localparam int unsigned PHASES_PER_CYCLE  = 8;
  localparam int unsigned RESET_HOLD_CLOCKS = 64;

  // ---------------------------------------------------------------
  // bus phases of one instruction cycle
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_A1, PH_A2, PH_A3, PH_FIRST_FETCH, PH_SECOND_FETCH, PH_X1, PH_X2, PH_X3
  } fbpc_phase_t;

  // ---------------------------------------------------------------
  // operation nibbles
  // ---------------------------------------------------------------
  localparam logic [3:0] OP_JUMP_COND  = 4'h1;
  localparam logic [3:0] OP_PAIR_IMM   = 4'h2;
  localparam logic [3:0] OP_PAIR_IND   = 4'h3;
  localparam logic [3:0] OP_JUMP_ABS   = 4'h4;
  localparam logic [3:0] OP_CALL       = 4'h5;
  localparam logic [3:0] OP_INC        = 4'h6;
  localparam logic [3:0] OP_BUMP_SKIP  = 4'h7;
  localparam logic [3:0] OP_ADD        = 4'h8;
  localparam logic [3:0] OP_SUB        = 4'h9;
  localparam logic [3:0] OP_LOAD       = 4'hA;
  localparam logic [3:0] OP_SWAP       = 4'hB;
  localparam logic [3:0] OP_RETURN     = 4'hC;
  localparam logic [3:0] OP_LOAD_IMM   = 4'hD;
  localparam logic [3:0] OP_IO         = 4'hE;
  localparam logic [3:0] OP_ACC_GROUP  = 4'hF;

  // ---------------------------------------------------------------
  // accumulator group and i/o modifiers
  // ---------------------------------------------------------------
  localparam logic [3:0] AG_CLEAR_BOTH  = 4'h0;
  localparam logic [3:0] AG_CLEAR_CARRY = 4'h1;
  localparam logic [3:0] AG_INC_ACC     = 4'h2;
  localparam logic [3:0] AG_CPL_CARRY   = 4'h3;
  localparam logic [3:0] AG_CPL_ACC     = 4'h4;
  localparam logic [3:0] AG_ROT_LEFT    = 4'h5;
  localparam logic [3:0] AG_ROT_RIGHT   = 4'h6;
  localparam logic [3:0] AG_CARRY_TO_A  = 4'h7;
  localparam logic [3:0] AG_DEC_ACC     = 4'h8;
  localparam logic [3:0] AG_CARRY_SUB   = 4'h9;
  localparam logic [3:0] AG_SET_CARRY   = 4'hA;
  localparam logic [3:0] AG_DEC_ADJUST  = 4'hB;
  localparam logic [3:0] AG_ONE_HOT_BIN = 4'hC;
  localparam logic [3:0] AG_CHOOSE_BANK = 4'hD;
  localparam logic [3:0] IO_SUB_CHAR    = 4'h8;
  localparam logic [3:0] IO_ADD_CHAR    = 4'hB;
  localparam logic [3:0] DEC_LIMIT      = 4'h9;
  localparam logic [3:0] DEC_CORRECTION = 4'h6;
  localparam logic [3:0] CARRY_SUB_ONE  = 4'hA;
  localparam logic [3:0] CARRY_SUB_ZERO = 4'h9;
  localparam logic [3:0] ONE_HOT_BAD    = 4'hF;
  localparam logic [1:0] STACK_TOP      = 2'h2;
  localparam logic [3:0] BANK_LINE_ZERO = 4'h1;

  // ---------------------------------------------------------------
  // carriers and state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] data;
    logic       oe;
  } fbpc_bus_t;

  typedef struct packed {
    fbpc_phase_t      phase;
    logic [11:0]      pc;
    logic [2:0][11:0] stack;
    logic [1:0]       sp;
    logic [15:0][3:0] regs;
    logic [3:0]       acc;
    logic             cy;
    logic [3:0]       operation_nibble;
    logic [3:0]       modifier_nibble;
    logic [7:0]       first_word;
    logic             second_word;
    logic             fetch_indirect;
    logic [2:0]       bank_code;
    fbpc_bus_t        bus;
    logic             sync;
    logic             rom_sel;
    logic [3:0]       bank_sel;
  } fbpc_state_t;

  localparam fbpc_state_t STATE_RESET = '{phase: PH_X3, default: '0};

endpackage

// ===== testbench.sv
// self-checking bench of the four-bit processor core
// assumes the memory partner holds the program; expectations are noted here
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                mclk;
  logic                srst;
  logic                test_in;
  logic [3:0]          bus_in;
  logic [3:0]          bus_last;
  logic [3:0]          rd_val;
  logic                mem_oe;
  logic [3:0]          mem_data;
  fbpc_pkg::fbpc_bus_t bus_drive;
  logic                cycle_sync;
  logic                program_memory_select;
  logic [3:0]          data_bank_select;
  logic [3:0]          exp_q[$];
  logic                t;
  logic [3:0]          r;
  int                  miscompares;
  int                  n_compared;
  int                  seed;
  int                  cycles;
  int                  since;
  int                  ph;
  bit                  seen;

  // ---------------------------------------------------------------
  // clock, shared bus and instances
  // ---------------------------------------------------------------
  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  // a released bus shows the inverse of its last level
  assign bus_in = bus_drive.oe ? bus_drive.data : (mem_oe ? mem_data : ~bus_last);

  fbpc_core i_dut (
    .mclk                  (mclk),
    .srst                  (srst),
    .test_in               (test_in),
    .bus_in                (bus_in),
    .bus_drive             (bus_drive),
    .cycle_sync            (cycle_sync),
    .program_memory_select (program_memory_select),
    .data_bank_select      (data_bank_select)
  );

  fbpc_mem i_mem (
    .mclk                  (mclk),
    .srst                  (srst),
    .bus_drive             (bus_drive),
    .cycle_sync            (cycle_sync),
    .program_memory_select (program_memory_select),
    .rd_val                (rd_val),
    .mem_oe                (mem_oe),
    .mem_data              (mem_data)
  );

  // ---------------------------------------------------------------
  // compare and closing
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("TB: compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic wait_empty;
    for (int i = 0; i < 800 && exp_q.size() != 0; i++) @(posedge mclk);
    if (exp_q.size() != 0) chk(8'(exp_q.size()), 8'h00);
  endtask

  // ---------------------------------------------------------------
  // monitor: cycle framing, selects and results driven at x2 and x3
  // ---------------------------------------------------------------
  always @(posedge mclk) begin
    bus_last <= bus_in;
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      end_sim();
    end
    if (srst) begin
      seen = 1'b0;
      since = 0;
    end else begin
      ph = cycle_sync ? 0 : since;
      if (cycle_sync) begin
        if (seen) chk(8'(since), 8'h08);
        seen = 1'b1;
        since = 1;
      end else begin
        since++;
      end
      if (seen && ph == 2) begin
        chk({7'h00, program_memory_select}, 8'h01);
        chk({4'h0, data_bank_select}, 8'h01);
      end
      if (seen && (ph == 6 || ph == 7) && bus_drive.oe === 1'b1) begin
        if (exp_q.size() == 0)
          chk({4'h0, bus_drive.data}, 8'hFF);
        else
          chk({4'h0, bus_drive.data}, {4'h0, exp_q.pop_front()});
      end
    end
  end

  // ---------------------------------------------------------------
  // stimulus: program run, then a full-length reset mid-run
  // ---------------------------------------------------------------
  initial begin
    seed = 2029;
    srst = 1'b1;
    test_in = 1'b0;
    rd_val = 4'h0;
    bus_last = 4'h0;
    miscompares = 0;
    n_compared = 0;
    cycles = 0;
    repeat (3) @(posedge mclk);
    t = 1'($random(seed));
    r = 4'($random(seed));
    // results: load, pair out, complement, increment, read, return, test jump, add
    exp_q = {4'h5, 4'h3, 4'hC, 4'hA, 4'hB, r, 4'h7, (t ? 4'h2 : 4'h1), 4'hF};
    test_in <= t;
    rd_val <= r;
    srst <= 1'b0;
    wait_empty();
    srst <= 1'b1;
    repeat (64) @(posedge mclk);
    exp_q = {4'h5};
    srst <= 1'b0;
    wait_empty();
    repeat (8) @(posedge mclk);
    end_sim();
  end
endmodule
